// *** common/drive_if_pkg.sv ***
// constants for the flexible disk drive control-input logic
// assumes a single 10 MHz clock; all interface pins are asynchronous to it
//
// What this block does
// - four active-low selects, host asserts only one
// - every receiver except motor-on, and every transmitter, gated by select
// - spindle runs while motor-on held low
// - one second spin-up before drive ready
// - step with direction low moves head inward
// - one track per step, at rising edge
// - write gate low records write data
// - write gate high enables stepping and read data
// - track zero flag, outward steps ignored there
// - index pulse 4 ms wide per revolution
// - write protect flagged and inhibits writing
package drive_if_pkg;
   // clock rate in hertz
   localparam int unsigned CLK_HZ = 10_000_000;
   // spin-up time in milliseconds
   localparam int unsigned SPIN_UP_MS = 1000;
   localparam int unsigned SPIN_UP_CYC = SPIN_UP_MS * (CLK_HZ / 1000);
   // index pulse width in microseconds (nominal)
   localparam int unsigned INDEX_US = 4000;
   localparam int unsigned INDEX_CYC = INDEX_US * (CLK_HZ / 1_000_000);
   // one spindle revolution at 300 rpm, in milliseconds
   localparam int unsigned REV_MS = 200;
   localparam int unsigned REV_PERIOD_CYC = REV_MS * (CLK_HZ / 1000);
   // highest track number (40-track drive)
   localparam logic [5:0] LAST_TRACK = 6'h27;
   // reset values
   localparam logic [5:0] TRACK_RST = 6'h00;
   // spindle states
   typedef enum logic [1:0] {
      SPIN_OFF = 2'b00,
      SPIN_UP = 2'b01,
      SPIN_READY = 2'b10
   } spin_state_t;
endpackage

// *** logic/disk_drive_control_interface.sv ***
// control-input side of a flexible disk drive interface
// assumes pins arrive asynchronously; one clock at 10 MHz, active-low reset
`timescale 1ns/1ps
`default_nettype none
module disk_drive_control_interface
   import drive_if_pkg::*;
#(
   // spin-up count, shorten for simulation
   parameter int unsigned SPIN_CYC = SPIN_UP_CYC,
   // index pulse width count, shorten for simulation
   parameter int unsigned IDX_CYC = INDEX_CYC,
   // revolution period in cycles (300 rpm = 200 ms)
   parameter int unsigned REV_CYC = REV_PERIOD_CYC
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // strap: which select line addresses this drive (0 optional .. 3)
   input wire logic [1:0] unit_addr_i,
   // active-low select pins from host
   input wire logic unit_select_optional_n_i,
   input wire logic unit_select_one_n_i,
   input wire logic unit_select_two_n_i,
   input wire logic unit_select_three_n_i,
   // control pins from host, active low
   input wire logic motor_on_n_i,
   input wire logic direction_n_i,
   input wire logic step_n_i,
   input wire logic write_gate_n_i,
   input wire logic write_data_n_i,
   // media sense: read-only diskette present
   input wire logic media_read_only_i,
   // recovered read data from head channel
   input wire logic read_data_raw_i,
   // spindle and head actuator
   output logic spindle_on_o,
   output logic head_step_o,
   output logic head_inward_o,
   output logic [5:0] track_o,
   output logic drive_ready_o,
   // write channel
   output logic write_enable_o,
   output logic write_data_o,
   // open-drain outputs to host: level low while driving, oe low = drive
   output logic track_zero_o,
   output logic track_zero_oe_n_o,
   output logic index_o,
   output logic index_oe_n_o,
   output logic write_protect_o,
   output logic write_protect_oe_n_o,
   output logic read_data_o,
   output logic read_data_oe_n_o
);
   // synchronised pins, bit order: media sel3 sel2 sel1 sel0 motor dir step wg wd
   logic [9:0] pins_s;
   // media sense idles low (writable disk), the host pins idle high
   pin_sync #(.W(10), .RST(10'h1FF)) u_sync (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .pin_i({media_read_only_i, unit_select_three_n_i, unit_select_two_n_i,
              unit_select_one_n_i, unit_select_optional_n_i, motor_on_n_i,
              direction_n_i, step_n_i, write_gate_n_i, write_data_n_i}),
      .sync_o(pins_s)
   );

   // decoded active-high levels
   wire [3:0] sel_all = ~pins_s[8:5];
   wire motor_s = ~pins_s[4];
   wire dir_in_s = ~pins_s[3];
   wire step_low_s = ~pins_s[2];
   wire wgate_s = ~pins_s[1];
   wire wdata_s = ~pins_s[0];
   // the media sensor is a pin as well; it must not reach logic unsynced
   wire read_only_s = pins_s[9];

   // only our own select line counts; others belong to other drives
   wire selected = sel_all[unit_addr_i];

   // gated receivers: write gate and step are accepted only when selected
   wire write_mode = selected & wgate_s;
   wire step_mode = selected & ~wgate_s;

   // spindle state; motor-on is not gated by select so power can stay on
   spin_state_t spin_q, spin_d;
   logic [23:0] spin_cnt_q, spin_cnt_d;
   // spin-up target cast once to the counter width
   wire [23:0] spin_last = 24'(SPIN_CYC - 1);

   // spin-up sequencing
   always_comb begin
      spin_d = spin_q;
      spin_cnt_d = spin_cnt_q;
      unique case (spin_q)
         SPIN_OFF: begin
            spin_cnt_d = 24'h00_0000;
            if (motor_s) begin
               spin_d = SPIN_UP;
            end
         end
         SPIN_UP: begin
            if (!motor_s) begin
               spin_d = SPIN_OFF;
            end else if (spin_cnt_q == spin_last) begin
               spin_d = SPIN_READY;
            end else begin
               spin_cnt_d = spin_cnt_q + 24'h00_0001;
            end
         end
         SPIN_READY: begin
            if (!motor_s) begin
               spin_d = SPIN_OFF;
            end
         end
         default: begin
            spin_d = SPIN_OFF;
         end
      endcase
   end

   // spindle registers
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         spin_q <= SPIN_OFF;
         spin_cnt_q <= 24'h00_0000;
      end else begin
         spin_q <= spin_d;
         spin_cnt_q <= spin_cnt_d;
      end
   end

   // step edge detect on the synced level only
   logic step_low_q;
   // head position; a limit stops motion rather than wrapping
   logic [5:0] track_q;
   // rising edge of the step pin ends the pulse; motion starts here
   wire step_rise = step_low_q & ~step_low_s;
   // direction sampled at that edge; host keeps it stable around it
   wire at_zero = (track_q == TRACK_RST);
   wire at_last = (track_q == LAST_TRACK);
   wire go_in = step_rise & step_mode & dir_in_s & ~at_last;
   wire go_out = step_rise & step_mode & ~dir_in_s & ~at_zero;

   // head move strobe and direction of the last move
   logic head_step_q;
   logic head_inward_q;

   // head position register, one track per accepted pulse
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         step_low_q <= 1'b0;
         track_q <= TRACK_RST;
         head_step_q <= 1'b0;
         head_inward_q <= 1'b0;
      end else begin
         step_low_q <= step_low_s;
         head_step_q <= go_in | go_out;
         if (go_in | go_out) begin
            head_inward_q <= go_in;
         end
         if (go_in) begin
            track_q <= track_q + 6'h01;
         end else if (go_out) begin
            track_q <= track_q - 6'h01;
         end
      end
   end

   // index generator: one pulse per revolution while spinning
   logic [21:0] rev_cnt_q;
   wire [21:0] rev_last = 22'(REV_CYC - 1);
   wire [21:0] idx_len = 22'(IDX_CYC);
   wire spinning = (spin_q != SPIN_OFF);
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rev_cnt_q <= 22'h00_0000;
      end else if (!spinning || rev_cnt_q == rev_last) begin
         rev_cnt_q <= 22'h00_0000;
      end else begin
         rev_cnt_q <= rev_cnt_q + 22'h00_0001;
      end
   end
   wire index_pulse = spinning & (rev_cnt_q < idx_len);

   // write path: blocked on read-only media and until spindle ready
   wire write_ok = write_mode & ~read_only_s & (spin_q == SPIN_READY);

   // registered outputs to the write channel and host transmitters
   logic write_en_q, write_data_q, tz_q, idx_q, wp_q, rd_q, rd_en_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         write_en_q <= 1'b0;
         write_data_q <= 1'b0;
         tz_q <= 1'b0;
         idx_q <= 1'b0;
         wp_q <= 1'b0;
         rd_q <= 1'b0;
         rd_en_q <= 1'b0;
      end else begin
         write_en_q <= write_ok;
         write_data_q <= write_ok & wdata_s;
         tz_q <= selected & at_zero;
         idx_q <= selected & index_pulse;
         wp_q <= selected & read_only_s;
         rd_q <= read_data_raw_i;
         rd_en_q <= step_mode;
      end
   end

   // drivers: host pin levels tied low, enable low only when asserting
   assign spindle_on_o = spinning;
   assign drive_ready_o = (spin_q == SPIN_READY);
   assign head_step_o = head_step_q;
   assign head_inward_o = head_inward_q;
   assign track_o = track_q;
   assign write_enable_o = write_en_q;
   assign write_data_o = write_data_q;
   assign track_zero_o = 1'b0;
   assign track_zero_oe_n_o = ~tz_q;
   assign index_o = 1'b0;
   assign index_oe_n_o = ~idx_q;
   assign write_protect_o = 1'b0;
   assign write_protect_oe_n_o = ~wp_q;
   // read data is a low pulse per recovered flux bit, gated by select
   assign read_data_o = 1'b0;
   assign read_data_oe_n_o = ~(rd_en_q & rd_q);
endmodule
`default_nettype wire

// *** logic/pin_sync.sv ***
// two-flop synchroniser for a bus of asynchronous pins
// assumes rst_n_i released synchronously by the system
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int W = 8,
   parameter logic [W-1:0] RST = '1
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // pins in, synced out
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] sync_o
);
   // first stage is read only by the second
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   // both stages reset to each pin's idle level, so no false edge follows reset
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= RST;
         sync_q <= RST;
      end else begin
         meta_q <= pin_i;
         sync_q <= meta_q;
      end
   end
   assign sync_o = sync_q;
endmodule
`default_nettype wire

// *** sim/drive_props.sv ***
// checker for the drive control-input logic
// assumes a bind onto the top module; one clock domain
`timescale 1ns/1ps
`default_nettype none
module drive_props
   import drive_if_pkg::*;
#(
   parameter int unsigned SPIN_CYC = 50
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // host pins
   input wire logic [1:0] unit_addr_i,
   input wire logic unit_select_optional_n_i,
   input wire logic unit_select_one_n_i,
   input wire logic unit_select_two_n_i,
   input wire logic unit_select_three_n_i,
   input wire logic motor_on_n_i,
   input wire logic write_gate_n_i,
   input wire logic media_read_only_i,
   // drive outputs
   input wire logic spindle_on_o,
   input wire logic head_step_o,
   input wire logic head_inward_o,
   input wire logic [5:0] track_o,
   input wire logic drive_ready_o,
   input wire logic write_enable_o,
   input wire logic track_zero_oe_n_o
);
   // own select, picked by the strap
   wire [3:0] sel_vec_n = {unit_select_three_n_i, unit_select_two_n_i,
      unit_select_one_n_i, unit_select_optional_n_i};
   wire sel_n = sel_vec_n[unit_addr_i];
   // spindle-on cycles, saturating so it never wraps
   int unsigned spin_q;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) spin_q <= 0;
      else if (!spindle_on_o) spin_q <= 0;
      else if (spin_q < SPIN_CYC) spin_q <= spin_q + 1;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   // pins held long enough to pass the synchronisers
   sequence s_away;
      sel_n[*5];
   endsequence
   sequence s_write;
      (!write_gate_n_i && !sel_n && !media_read_only_i && drive_ready_o)[*6];
   endsequence
   AST_MOTOR_ON: assert property ((!motor_on_n_i)[*4] |-> spindle_on_o)
      else $error("spindle not on");
   AST_MOTOR_OFF: assert property (motor_on_n_i[*4] |-> !spindle_on_o && !drive_ready_o)
      else $error("spindle not off");
   AST_SPIN_UP: assert property (drive_ready_o |-> spin_q == SPIN_CYC)
      else $error("ready too early");
   AST_IN: assert property (head_step_o && head_inward_o |-> track_o == $past(track_o) + 6'h01)
      else $error("inward move wrong");
   AST_OUT: assert property (head_step_o && !head_inward_o |-> track_o == $past(track_o) - 6'h01)
      else $error("outward move wrong");
   AST_HOLD: assert property (!head_step_o |-> $stable(track_o) && track_o <= LAST_TRACK)
      else $error("track moved without step");
   AST_UNSEL: assert property (s_away |-> !head_step_o && track_zero_oe_n_o)
      else $error("unselected drive active");
   AST_GATE: assert property ((!write_gate_n_i)[*5] |-> !head_step_o ##1 !head_step_o)
      else $error("step while writing");
   AST_WR: assert property (s_write |-> write_enable_o)
      else $error("write not enabled");
   AST_WP: assert property (media_read_only_i[*4] |-> !write_enable_o)
      else $error("write on read-only media");
endmodule
`default_nettype wire

// *** sim/host_model.sv ***
// host controller model driving select, motor, step and gate pins
// assumes the bench calls its tasks just after a falling edge
`timescale 1ns/1ps
`default_nettype none
module host_model #(
   parameter int GAP = 250_000
) (
   // clock
   input wire logic clk_i,
   // pins to the drive, active low
   output logic [3:0] sel_n_o,
   output logic motor_n_o,
   output logic dir_n_o,
   output logic step_n_o,
   output logic gate_n_o
);
   initial begin
      sel_n_o = 4'hf;
      {motor_n_o, dir_n_o, step_n_o, gate_n_o} = 4'hf;
   end
   // only one select low at a time, held through every exchange
   task automatic sel(input int u);
      sel_n_o = ~(4'h1 << u);
   endtask
   // one step: settle direction, low pulse, hold, then spacing
   task automatic step(input logic inward);
      dir_n_o = !inward;
      repeat (10) @(negedge clk_i);
      step_n_o = 1'b0;
      repeat (10) @(negedge clk_i);
      step_n_o = 1'b1;
      repeat (10) @(negedge clk_i);
      dir_n_o = inward; // hold over: show the wrong way on purpose
      repeat (GAP) @(negedge clk_i);
   endtask
endmodule
`default_nettype wire

// *** sim/test_disk_drive_control_interface.sv ***
// self-checking bench for the drive control-input logic
// assumes short spin, index and revolution counts set below
`timescale 1ns/1ps
`default_nettype none
module test_disk_drive_control_interface
   import drive_if_pkg::*;
;
   localparam int SPIN = 50, IDX = 5, REV = 40;
   logic clk_i = 0, rst_n_i = 0, media_read_only_i = 0, read_data_raw_i = 0;
   logic write_data_n_i = 1;
   logic [1:0] unit_addr_i = 0;
   wire unit_select_optional_n_i, unit_select_one_n_i, unit_select_two_n_i;
   wire unit_select_three_n_i, motor_on_n_i, direction_n_i, step_n_i, write_gate_n_i;
   wire spindle_on_o, head_step_o, head_inward_o, drive_ready_o, write_enable_o;
   wire write_data_o, track_zero_o, track_zero_oe_n_o, index_o, index_oe_n_o;
   wire write_protect_o, write_protect_oe_n_o, read_data_o, read_data_oe_n_o;
   wire [5:0] track_o;
   int seed = 32'he711, bad_count = 0, tests_run = 0, cyc = 0, n, i;
   logic [5:0] exp_trk;
   always #50 clk_i = ~clk_i;
   // write data keeps toggling so the write path is never idle
   always @(negedge clk_i) write_data_n_i <= ~write_data_n_i;
   host_model #(.GAP(20)) host_u (.clk_i(clk_i), .sel_n_o({unit_select_three_n_i,
      unit_select_two_n_i, unit_select_one_n_i, unit_select_optional_n_i}),
      .motor_n_o(motor_on_n_i), .dir_n_o(direction_n_i), .step_n_o(step_n_i),
      .gate_n_o(write_gate_n_i));
   disk_drive_control_interface #(.SPIN_CYC(SPIN), .IDX_CYC(IDX), .REV_CYC(REV)) dut_u (.*);
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", tests_run, bad_count);
      if (bad_count == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // track expected after one accepted step, clamped at both ends
   function automatic logic [5:0] nxt(input logic [5:0] t, input logic inward);
      if (inward) return (t == LAST_TRACK) ? t : t + 6'h01;
      return (t == 6'h00) ? t : t - 6'h01;
   endfunction
   task automatic do_step(input logic inward);
      host_u.step(inward);
      exp_trk = nxt(exp_trk, inward);
      chk(track_o, exp_trk);
   endtask
   // a hang is cut short well past the expected run length
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         bad_count++;
         stop_test();
      end
   end
   initial begin
      unit_addr_i = 2'($random(seed));
      repeat (6) @(negedge clk_i);
      rst_n_i = 1;
      chk({track_o, spindle_on_o, track_zero_oe_n_o, index_oe_n_o}, {6'h00, 3'b011});
      // open-drain levels never leave low; only the enables move
      chk({track_zero_o, index_o, write_protect_o, read_data_o}, 4'h0);
      host_u.motor_n_o = 0;
      for (n = 0; n < 200 && drive_ready_o !== 1'b1; n++) @(negedge clk_i);
      chk(n >= SPIN && n <= SPIN + 6, 1);
      chk(spindle_on_o, 1);
      host_u.sel(unit_addr_i);
      exp_trk = 0;
      do_step(0);
      chk(track_zero_oe_n_o, 0);
      for (i = 0; i < 41; i++) do_step(1);
      for (i = 0; i < 20; i++) do_step(1'($random(seed)));
      // step whichever way would move, so only the gating can stop it
      host_u.sel(2'(unit_addr_i + 2'd1));
      host_u.step(exp_trk != LAST_TRACK);
      chk({track_o, index_oe_n_o}, {exp_trk, 1'b1});
      host_u.sel(unit_addr_i);
      host_u.gate_n_o = 0;
      read_data_raw_i = 1;
      repeat (6) @(negedge clk_i);
      chk(write_enable_o, 1);
      // written data follows the pin inverted; two toggles behind is in phase
      chk(write_data_o, !write_data_n_i);
      host_u.step(exp_trk != LAST_TRACK);
      chk(track_o, exp_trk);
      chk(read_data_oe_n_o, 1);
      media_read_only_i = 1;
      repeat (6) @(negedge clk_i);
      chk({write_enable_o, write_protect_oe_n_o}, 0);
      {media_read_only_i, host_u.gate_n_o} = 2'b01;
      // two whole revolutions hold exactly two index pulses
      n = 0;
      repeat (2 * REV) @(negedge clk_i) n += (index_oe_n_o === 1'b0);
      chk(n, 2 * IDX);
      // write gate high again: recovered data reaches the host line
      chk(read_data_oe_n_o, 0);
      host_u.motor_n_o = 1;
      repeat (6) @(negedge clk_i);
      chk({spindle_on_o, drive_ready_o}, 0);
      stop_test();
   end
endmodule
bind disk_drive_control_interface drive_props #(.SPIN_CYC(SPIN_CYC)) props_u (.*);
`default_nettype wire
